// ---- core/pcwl_loader.sv ----
`timescale 1ns/1ps
// Summary of operation
// R01: port 1 takes its configuration word from word address 62h.
// R02: ports 2 and 3 take their words from word addresses 64h and 66h.
// R03: port 4 takes its word from word address 68h.
// R04: port 5 takes its word from word address 6Ah.
// R05: word bit 0 becomes the slot-implemented bit (C0h bit 24).
// R06: word bit 1 becomes the slot clock source bit (D0h bit 28).
// R07: word bit 2 becomes the device-specific init bit (40h bit 21).
// R08: word bit 3 puts VC1 into the low-priority group (144h bit 4).
// R09: word bits 6:4 become the logical port number (CCh bits 26:24).
// R10: word bits 15:9 become the TC-to-VC0 map (154h bits 7:1).
// R11: port 0 takes its word from word address 60h with the same layout.
// R12: word bits 8:7 are ignored; an absent word leaves its fields as they were.
// R13: every port word that is not absent is applied once after reset, before the ports use them.
module pcwl_loader #(
   parameter int NUM_PORTS = pcwl_pkg::NUM_PORTS
) (
   input  wire logic                      hclk,
   input  wire logic                      hresetn,
   input  wire logic                      clk_en,
   input  wire logic                      hsel,
   input  wire logic [31:0]               haddr,
   input  wire logic [1:0]                htrans,
   input  wire logic                      hwrite,
   input  wire logic [2:0]                hsize,
   input  wire logic [31:0]               hwdata,
   input  wire logic                      hready,
   output logic                           hreadyout,
   output logic [31:0]                    hrdata,
   output logic                           hresp,
   output logic                           cfg_req,
   output logic [7:0]                     cfg_addr,
   input  wire logic [15:0]               cfg_rdata,
   input  wire logic                      cfg_ack,
   input  wire logic                      cfg_absent,
   output pcwl_pkg::pcwl_port_cfg_type    port_cfg [NUM_PORTS],
   output logic                           cfg_applied
);

   // ***************************************************************
   // declarations
   // ***************************************************************
   logic                              boot_q;
   logic                              start;
   logic                              busy;
   logic                              done;
   logic [pcwl_pkg::IDX_W-1:0]        cur_idx;
   pcwl_pkg::pcwl_word_type           word;
   logic [NUM_PORTS-1:0]              loaded_q;
   logic [NUM_PORTS-1:0]              absent_q;
   logic                              wr_pend_q;
   logic [7:0]                        wr_addr_q;
   logic                              ahb_go;
   logic                              reload_wr;
   logic                              apply;
   logic [7:0]                        port_off;
   logic [pcwl_pkg::IDX_W-1:0]        port_idx;
   logic                              port_hit;
   logic                              map_hit;
   logic [31:0]                       status_word;
   logic [31:0]                       rd_word;

   // ***************************************************************
   // word fetch sequencer
   // ***************************************************************
   pcwl_fetch #(
      .NUM_PORTS (NUM_PORTS)
   ) u_fetch (
      .hclk       (hclk),
      .hresetn    (hresetn),
      .clk_en     (clk_en),
      .start      (start),
      .busy       (busy),
      .done       (done),
      .mem_req    (cfg_req),
      .mem_addr   (cfg_addr),
      .mem_rdata  (cfg_rdata),
      .mem_ack    (cfg_ack),
      .mem_absent (cfg_absent),
      .cur_idx    (cur_idx),
      .word       (word)
   );

   // ***************************************************************
   // bus decode
   // ***************************************************************
   // the high 24 address bits must be zero; any address above FFh reads as zero
   assign ahb_go    = hsel & htrans[1] & hready;
   assign map_hit   = (haddr[31:8] == 24'h00_0000);
   assign port_off  = haddr[7:0] - pcwl_pkg::ADDR_PORT_BASE;
   assign port_idx  = port_off[4:2];
   assign port_hit  = map_hit && (port_off[7:5] == 3'b000) &&
                      (port_off[1:0] == 2'b00) &&
                      (32'(port_idx) < NUM_PORTS);
   assign reload_wr = wr_pend_q && (wr_addr_q == pcwl_pkg::ADDR_CTRL) &&
                      hwdata[pcwl_pkg::CTRL_RELOAD];

   // boot kick or software reload; ignored while a pass runs or just ends,
   // so a reload never meets the done pulse that raises applied
   assign start = (boot_q | reload_wr) & ~busy & ~done;    // see R13
   assign apply = word.valid & ~word.absent;               // see R12

   // status word shows the loader's own progress
   always_comb
   begin
      status_word                                  = 32'h0000_0000;
      status_word[pcwl_pkg::ST_BUSY]               = busy;
      status_word[pcwl_pkg::ST_APPLIED]            = cfg_applied;
      status_word[pcwl_pkg::ST_LOADED_LO +: NUM_PORTS] = loaded_q;
      status_word[pcwl_pkg::ST_ABSENT_LO +: NUM_PORTS] = absent_q;
   end

   assign rd_word =
      port_hit ? {16'h0000, pcwl_pkg::encode_word(port_cfg[port_idx])} :
      (map_hit && haddr[7:0] == pcwl_pkg::ADDR_STATUS) ? status_word :
      32'h0000_0000;

   // ***************************************************************
   // bus slave: zero wait states, always OKAY
   // ***************************************************************
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         wr_pend_q <= 1'b0;
         wr_addr_q <= 8'h00;
         hrdata    <= pcwl_pkg::HRDATA_RST;
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end
      else if (clk_en)
      begin
         wr_pend_q <= ahb_go & hwrite & map_hit;
         wr_addr_q <= haddr[7:0];
         hrdata    <= (ahb_go & ~hwrite) ? rd_word : 32'h0000_0000;
      end
   end

   // ***************************************************************
   // boot kick: one request for a pass right after reset release
   // ***************************************************************
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         boot_q <= 1'b1;
      else if (clk_en)
         boot_q <= 1'b0;                                   // see R13
   end

   // ***************************************************************
   // field images handed to the port logic
   // ***************************************************************
   // an absent word keeps whatever the fields held before
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         for (int p = 0; p < NUM_PORTS; p++)
            port_cfg[p] <= pcwl_pkg::CFG_RST;
      end
      else if (clk_en && apply)
         port_cfg[word.idx] <= pcwl_pkg::decode_word(word.data); // see R05
   end

   // ***************************************************************
   // progress flags
   // ***************************************************************
   // applied drops during a reload so ports never see a half pass
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         loaded_q    <= '0;
         absent_q    <= '0;
         cfg_applied <= 1'b0;
      end
      else if (clk_en)
      begin
         if (start)
         begin
            loaded_q    <= '0;
            absent_q    <= '0;
            cfg_applied <= 1'b0;
         end
         if (apply)
            loaded_q[word.idx] <= 1'b1;
         if (word.valid && word.absent)
            absent_q[word.idx] <= 1'b1;                    // see R12
         if (done)
            cfg_applied <= 1'b1;                           // see R13
      end
   end

   // ***************************************************************
   // assertions
   // ***************************************************************
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   logic                              chk_apply_q;
   logic [pcwl_pkg::IDX_W-1:0]        chk_idx_q;
   logic [15:0]                       chk_data_q;
   pcwl_pkg::pcwl_port_cfg_type       chk_old_q;
   logic                              chk_absent_q;

   // helper: remember what was applied, and the image before it
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         chk_apply_q  <= 1'b0;
         chk_absent_q <= 1'b0;
         chk_idx_q    <= '0;
         chk_data_q   <= 16'h0000;
         chk_old_q    <= pcwl_pkg::CFG_RST;
      end
      else
      begin
         chk_apply_q  <= clk_en & apply;
         chk_absent_q <= clk_en & word.valid & word.absent;
         chk_idx_q    <= word.idx;
         chk_data_q   <= word.data;
         chk_old_q    <= port_cfg[word.idx];
      end
   end

   // memory link: one address per port, held until it is answered
   a_port0_addr: assert property (cfg_req && cur_idx == 3'h0 |->   // see R11
      cfg_addr == pcwl_pkg::WADDR_PORT0) else $error("port 0 address");

   a_port1_addr: assert property (cfg_req && cur_idx == 3'h1 |->   // see R01
      cfg_addr == pcwl_pkg::WADDR_PORT1) else $error("port 1 address");

   a_port23_addr: assert property (cfg_req && cur_idx[2:1] == 2'b01 |-> // see R02
      cfg_addr == (cur_idx[0] ? pcwl_pkg::WADDR_PORT3 :
                   pcwl_pkg::WADDR_PORT2)) else $error("port 2/3 address");

   a_port4_addr: assert property (cfg_req && cur_idx == 3'h4 |->   // see R03
      cfg_addr == pcwl_pkg::WADDR_PORT4) else $error("port 4 address");

   a_port5_addr: assert property (cfg_req && cur_idx == 3'h5 |->   // see R04
      cfg_addr == pcwl_pkg::WADDR_PORT5) else $error("port 5 address");

   a_req_hold: assert property (cfg_req && !cfg_ack |=>           // see R13
      cfg_req && $stable(cfg_addr)) else $error("request dropped early");

   a_req_gap: assert property (cfg_req && cfg_ack |=> !cfg_req)   // see R13
      else $error("no gap after answer");

   a_word_next: assert property (cfg_req && cfg_ack &&            // see R02
      32'(cur_idx) < NUM_PORTS - 1 |=> ##1 cfg_req &&
      cfg_addr == $past(cfg_addr, 2) + 8'h02) else $error("word order");

   a_idle_no_req: assert property (!busy |-> !cfg_req)           // see R13
      else $error("request while idle");

   // field images follow the word bits; bits 8:7 never land
   a_slot_clk_bits: assert property (chk_apply_q |->               // see R05
      port_cfg[chk_idx_q].slot_implemented == chk_data_q[0] &&
      port_cfg[chk_idx_q].slot_clock_ref == chk_data_q[1])          // see R06
      else $error("slot bits wrong");

   a_dsi_lowp_bits: assert property (chk_apply_q |->               // see R07
      port_cfg[chk_idx_q].dev_init_req == chk_data_q[2] &&
      port_cfg[chk_idx_q].low_priority_channel_count == chk_data_q[3]) // see R08
      else $error("init or channel bit wrong");

   a_port_number: assert property (chk_apply_q |->                 // see R09
      port_cfg[chk_idx_q].logical_port == chk_data_q[6:4])
      else $error("logical port wrong");

   a_tc_map: assert property (chk_apply_q |->                      // see R10
      port_cfg[chk_idx_q].tc_vc0_map == chk_data_q[15:9])
      else $error("tc map wrong");

   a_absent_keep: assert property (chk_absent_q |->                // see R12
      port_cfg[chk_idx_q] == chk_old_q) else $error("absent word applied");

   a_ignore_bits: assert property (chk_apply_q |->                 // see R12
      pcwl_pkg::encode_word(port_cfg[chk_idx_q]) ==
      (chk_data_q & 16'hFE7F)) else $error("unused word bits landed");

   a_absent_flag: assert property (chk_absent_q |->                // see R12
      absent_q[chk_idx_q] && !loaded_q[chk_idx_q])
      else $error("absent word not flagged");

   // pass bookkeeping
   a_boot_pass: assert property (boot_q && clk_en |=> busy)        // see R13
      else $error("no pass after reset");

   a_applied_idle: assert property (cfg_applied |-> !busy &&       // see R13
      !cfg_req) else $error("applied while fetching");

   a_done_applied: assert property (done |=> cfg_applied)          // see R13
      else $error("applied not raised");

   a_reload_clear: assert property (start |=> busy && !cfg_applied) // see R13
      else $error("reload left applied set");

   a_handled_all: assert property (cfg_applied |->                 // see R13
      (loaded_q | absent_q) == {NUM_PORTS{1'b1}})
      else $error("applied before every word");

   // main scenarios
   c_pass_done:   cover property (busy ##[1:200] cfg_applied);
   c_absent_word: cover property (word.valid && word.absent);
   c_reload:      cover property (cfg_applied ##1 reload_wr ##1 busy);
   c_reload_busy: cover property (reload_wr && busy);

endmodule : pcwl_loader

// ---- core/pcwl_pkg.sv ----
package pcwl_pkg;

   // ***************************************************************
   // sizes
   // ***************************************************************
   localparam int IDX_W     = 3;
   localparam int NUM_PORTS = 6;

   // ***************************************************************
   // word addresses in the configuration memory, one per port
   // ***************************************************************
   localparam logic [7:0] WADDR_PORT0 = 8'h60;
   localparam logic [7:0] WADDR_PORT1 = 8'h62;
   localparam logic [7:0] WADDR_PORT2 = 8'h64;
   localparam logic [7:0] WADDR_PORT3 = 8'h66;
   localparam logic [7:0] WADDR_PORT4 = 8'h68;
   localparam logic [7:0] WADDR_PORT5 = 8'h6A;

   // ***************************************************************
   // field positions inside a port word
   // ***************************************************************
   localparam int W_SLOT    = 0;
   localparam int W_CLK     = 1;
   localparam int W_DSI     = 2;
   localparam int W_LOWP    = 3;
   localparam int W_PNUM_LO = 4;
   localparam int W_PNUM_HI = 6;
   localparam int W_TC_LO   = 9;
   localparam int W_TC_HI   = 15;

   // ***************************************************************
   // destination register offsets and bit positions in port logic
   // ***************************************************************
   localparam logic [11:0] T_SLOT_OFF = 12'h0C0;
   localparam int          T_SLOT_BIT = 24;
   localparam logic [11:0] T_CLK_OFF  = 12'h0D0;
   localparam int          T_CLK_BIT  = 28;
   localparam logic [11:0] T_DSI_OFF  = 12'h040;
   localparam int          T_DSI_BIT  = 21;
   localparam logic [11:0] T_LOWP_OFF = 12'h144;
   localparam int          T_LOWP_BIT = 4;
   localparam logic [11:0] T_PNUM_OFF = 12'h0CC;
   localparam int          T_PNUM_LO  = 24;
   localparam logic [11:0] T_TC_OFF   = 12'h154;
   localparam int          T_TC_LO    = 1;

   // ***************************************************************
   // bus register map (byte addresses)
   // ***************************************************************
   localparam logic [7:0] ADDR_CTRL      = 8'h00;
   localparam logic [7:0] ADDR_STATUS    = 8'h04;
   localparam logic [7:0] ADDR_PORT_BASE = 8'h20;
   localparam int         CTRL_RELOAD    = 0;
   localparam int         ST_BUSY        = 0;
   localparam int         ST_APPLIED     = 1;
   localparam int         ST_LOADED_LO   = 8;
   localparam int         ST_ABSENT_LO   = 16;

   // ***************************************************************
   // types
   // ***************************************************************
   typedef struct packed {
      logic [6:0] tc_vc0_map;
      logic [2:0] logical_port;
      logic       low_priority_channel_count;
      logic       dev_init_req;
      logic       slot_clock_ref;
      logic       slot_implemented;
   } pcwl_port_cfg_type;

   typedef struct packed {
      logic             valid;
      logic             absent;
      logic [IDX_W-1:0] idx;
      logic [15:0]      data;
   } pcwl_word_type;

   typedef enum logic [1:0] {
      PCWL_IDLE = 2'b00,
      PCWL_REQ  = 2'b01,
      PCWL_NEXT = 2'b10
   } pcwl_state_type;

   localparam pcwl_port_cfg_type CFG_RST = '0;
   localparam logic [31:0]       HRDATA_RST = 32'h0000_0000;

   // ***************************************************************
   // functions
   // ***************************************************************
   // port index to word address
   function automatic logic [7:0] word_addr(input logic [IDX_W-1:0] idx);
      logic [7:0] a;
      a = WADDR_PORT0;                     // see R11
      case (idx)
         3'h1:    a = WADDR_PORT1;         // see R01
         3'h2:    a = WADDR_PORT2;         // see R02
         3'h3:    a = WADDR_PORT3;         // see R02
         3'h4:    a = WADDR_PORT4;         // see R03
         3'h5:    a = WADDR_PORT5;         // see R04
         default: a = WADDR_PORT0;         // see R11
      endcase
      return a;
   endfunction : word_addr

   // bits 8:7 of a word are never looked at
   function automatic pcwl_port_cfg_type decode_word(input logic [15:0] w);
      pcwl_port_cfg_type c;
      c.slot_implemented           = w[W_SLOT];              // see R05
      c.slot_clock_ref             = w[W_CLK];               // see R06
      c.dev_init_req               = w[W_DSI];               // see R07
      c.low_priority_channel_count = w[W_LOWP];              // see R08
      c.logical_port               = w[W_PNUM_HI:W_PNUM_LO]; // see R09
      c.tc_vc0_map                 = w[W_TC_HI:W_TC_LO];     // see R10
      return c;                                              // see R12
   endfunction : decode_word

   // readback places each field back at its word position
   function automatic logic [15:0] encode_word(input pcwl_port_cfg_type c);
      logic [15:0] w;
      w                     = 16'h0000;
      w[W_SLOT]             = c.slot_implemented;
      w[W_CLK]              = c.slot_clock_ref;
      w[W_DSI]              = c.dev_init_req;
      w[W_LOWP]             = c.low_priority_channel_count;
      w[W_PNUM_HI:W_PNUM_LO] = c.logical_port;
      w[W_TC_HI:W_TC_LO]    = c.tc_vc0_map;
      return w;
   endfunction : encode_word

endpackage : pcwl_pkg

// ---- core/pcwl_fetch.sv ----
`timescale 1ns/1ps
module pcwl_fetch #(
   parameter int NUM_PORTS = pcwl_pkg::NUM_PORTS
) (
   input  wire logic                      hclk,
   input  wire logic                      hresetn,
   input  wire logic                      clk_en,
   input  wire logic                      start,
   output logic                           busy,
   output logic                           done,
   output logic                           mem_req,
   output logic [7:0]                     mem_addr,
   input  wire logic [15:0]               mem_rdata,
   input  wire logic                      mem_ack,
   input  wire logic                      mem_absent,
   output logic [pcwl_pkg::IDX_W-1:0]     cur_idx,
   output pcwl_pkg::pcwl_word_type        word
);

   localparam logic [pcwl_pkg::IDX_W-1:0] LAST_IDX =
      pcwl_pkg::IDX_W'(NUM_PORTS - 1);
   localparam logic [pcwl_pkg::IDX_W-1:0] ONE_IDX = 3'h1;

   pcwl_pkg::pcwl_state_type          state_q, state_d;
   logic [pcwl_pkg::IDX_W-1:0]        idx_q, idx_d;
   logic                              req_d, done_d;
   pcwl_pkg::pcwl_word_type           word_d;

   // ***************************************************************
   // sequencer: one word per port, lowest port first
   // ***************************************************************
   always_comb
   begin
      state_d       = state_q;
      idx_d         = idx_q;
      req_d         = 1'b0;
      done_d        = 1'b0;
      word_d        = '0;
      word_d.idx    = idx_q;
      unique case (state_q)
         pcwl_pkg::PCWL_IDLE:
         begin
            if (start)
            begin
               idx_d   = '0;
               req_d   = 1'b1;
               state_d = pcwl_pkg::PCWL_REQ;
            end
         end
         pcwl_pkg::PCWL_REQ:
         begin
            req_d = 1'b1;
            if (mem_ack)
            begin
               req_d         = 1'b0;
               word_d.valid  = 1'b1;
               word_d.absent = mem_absent;
               word_d.data   = mem_rdata;
               state_d       = pcwl_pkg::PCWL_NEXT;
            end
         end
         pcwl_pkg::PCWL_NEXT:
         begin
            if (idx_q == LAST_IDX)
            begin
               done_d  = 1'b1;
               state_d = pcwl_pkg::PCWL_IDLE;
            end
            else
            begin
               idx_d   = idx_q + ONE_IDX;
               req_d   = 1'b1;
               state_d = pcwl_pkg::PCWL_REQ;
            end
         end
         default: state_d = pcwl_pkg::PCWL_IDLE;  // illegal code recovers
      endcase
   end

   // ***************************************************************
   // state flops, frozen while clk_en is low
   // ***************************************************************
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         state_q  <= pcwl_pkg::PCWL_IDLE;
         idx_q    <= '0;
         mem_req  <= 1'b0;
         mem_addr <= pcwl_pkg::WADDR_PORT0;
         done     <= 1'b0;
         word     <= '0;
      end
      else if (clk_en)
      begin
         state_q  <= state_d;
         idx_q    <= idx_d;
         mem_req  <= req_d;
         mem_addr <= pcwl_pkg::word_addr(idx_d);   // see R01
         done     <= done_d;
         word     <= word_d;
      end
   end

   assign busy    = (state_q != pcwl_pkg::PCWL_IDLE);
   assign cur_idx = idx_q;

endmodule : pcwl_fetch

// ---- verif/pcwl_cfg_mem.sv ----
`timescale 1ns/1ps
// ***************************************************************
// configuration memory model, answers after a set number of cycles
// ***************************************************************
module pcwl_cfg_mem (
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        cfg_req,
   input  wire logic [7:0]  cfg_addr,
   input  wire logic [15:0] words [6],
   input  wire logic [5:0]  absent_mask,
   input  wire logic [3:0]  delay,
   output logic             cfg_ack,
   output logic [15:0]      cfg_rdata,
   output logic             cfg_absent
);
   logic [3:0] wait_q;
   logic [2:0] idx;

   // word address back to port slot
   assign idx = 3'((cfg_addr - 8'h60) >> 1);

   // one ack pulse per request; data lines churn outside the ack cycle
   always @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         cfg_ack    <= 1'b0;
         cfg_rdata  <= 16'h0000;
         cfg_absent <= 1'b0;
         wait_q     <= 4'h0;
      end
      else if (cfg_req && !cfg_ack && wait_q >= delay)
      begin
         cfg_ack    <= 1'b1;
         // an absent word still puts junk on the data lines
         cfg_rdata  <= absent_mask[idx] ? ~words[idx] : words[idx];
         cfg_absent <= absent_mask[idx];
         wait_q     <= 4'h0;
      end
      else
      begin
         cfg_ack    <= 1'b0;
         cfg_rdata  <= ~cfg_rdata;
         cfg_absent <= ~cfg_absent;
         wait_q     <= (cfg_req && !cfg_ack) ? wait_q + 4'h1 : 4'h0;
      end
   end
endmodule : pcwl_cfg_mem

// ---- verif/pcwl_loader_tb.sv ----
`timescale 1ns/1ps
module pcwl_loader_tb;
   logic        hclk = 1'b0;
   logic        hresetn = 1'b0;
   logic        hsel = 1'b0;
   logic [31:0] haddr = 32'h0000_0000;
   logic [1:0]  htrans = 2'h0;
   logic        hwrite = 1'b0;
   logic [2:0]  hsize = 3'h2;
   logic [31:0] hwdata = 32'h0000_0000;
   logic [31:0] hrdata, rd;
   logic        hreadyout, hresp, cfg_req, cfg_ack, cfg_absent, cfg_applied;
   logic [7:0]  cfg_addr;
   logic [15:0] cfg_rdata, mem_w [6], exp_w [6];
   logic [5:0]  mask;
   logic [3:0]  delay;
   pcwl_pkg::pcwl_port_cfg_type port_cfg [6];
   int          seed, n_fail = 0, n_checks = 0, n_ack = 0, cyc = 0;

   always #5 hclk = ~hclk;

   pcwl_loader u_pcwl_loader (.hclk(hclk), .hresetn(hresetn),
      .clk_en(1'b1), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
      .cfg_req(cfg_req), .cfg_addr(cfg_addr), .cfg_rdata(cfg_rdata),
      .cfg_ack(cfg_ack), .cfg_absent(cfg_absent), .port_cfg(port_cfg),
      .cfg_applied(cfg_applied));

   pcwl_cfg_mem u_pcwl_cfg_mem (.hclk(hclk), .hresetn(hresetn),
      .cfg_req(cfg_req), .cfg_addr(cfg_addr), .words(mem_w),
      .absent_mask(mask), .delay(delay), .cfg_ack(cfg_ack),
      .cfg_rdata(cfg_rdata), .cfg_absent(cfg_absent));

   // ***************************************************************
   // tasks
   // ***************************************************************
   task automatic check(input string nm, input logic [31:0] seen, exp);
      n_checks++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("FAIL %s expected %h seen %h", nm, exp, seen);
      end
   endtask : check

   task automatic print_verdict();
      $display("comparisons %0d mismatches %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : print_verdict

   // one single transfer; entered just after a rising edge
   task automatic ahb(input logic wr, input logic [31:0] a, wd);
      hsel   <= 1'b1;
      haddr  <= a;
      htrans <= 2'h2;
      hwrite <= wr;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      hsel   <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rd = hrdata;
      check("hresp", 32'(hresp), 32'h0);
   endtask : ahb

   // new memory image; absent ports keep what they had
   task automatic fill(input logic [5:0] m, input logic [3:0] d, input bit c);
      logic [15:0] w;
      mask  <= m;
      delay <= d;
      for (int k = 0; k < 6; k++)
      begin
         w = 16'($random(seed));
         if (c && k < 2)
            w = (k == 0) ? 16'hFFFF : 16'h0180;
         mem_w[k] <= w;
         if (!m[k])
            exp_w[k] = w;
      end
   endtask : fill

   function automatic logic [31:0] exp_cfg(input logic [15:0] w);
      return {18'h0, w[15:9], w[6:4], w[3], w[2], w[1], w[0]};
   endfunction : exp_cfg

   task automatic wait_pass();
      for (int t = 0; t < 500 && cfg_applied !== 1'b1; t++)
         @(posedge hclk);
      check("applied", 32'(cfg_applied), 32'h1);
   endtask : wait_pass

   task automatic verify();
      check("word count", 32'(n_ack), 32'h6);
      n_ack = 0;
      for (int k = 0; k < 6; k++)
      begin
         check("port cfg", 32'(port_cfg[k]), exp_cfg(exp_w[k]));
         ahb(1'b0, 32'h20 + 32'(4 * k), 32'h0);
         check("port reg", rd, {16'h0, exp_w[k] & 16'hFE7F});
      end
      ahb(1'b0, 32'h04, 32'h0);
      check("status", rd, {10'h0, mask, 2'h0, ~mask, 6'h0, 2'h2});
   endtask : verify

   // ***************************************************************
   // watchdog and memory address order
   // ***************************************************************
   always @(posedge hclk)
   begin
      cyc = cyc + 1;
      if (cfg_req === 1'b1 && cfg_ack === 1'b1)
      begin
         check("word addr", 32'(cfg_addr), 32'h60 + 32'(2 * (n_ack % 6)));
         n_ack = n_ack + 1;
      end
      if (cyc == 20000)
      begin
         n_fail++;
         print_verdict();
      end
   end

   // boot pass, corner reload, random reload, then bus corners
   initial
   begin
      seed = 32'h001b;
      fill(6'h00, 4'h3, 1'b0);
      repeat (3) @(posedge hclk);
      for (int k = 0; k < 6; k++)
         check("reset cfg", 32'(port_cfg[k]), 32'h0);
      hresetn <= 1'b1;
      for (int p = 0; p < 3; p++)
      begin
         if (p > 0)
         begin
            fill(p == 1 ? 6'h24 : 6'($random(seed)), 4'($random(seed)), p == 1);
            ahb(1'b1, 32'h0, 32'h1);
            repeat (2) @(posedge hclk);
         end
         wait_pass();
         verify();
      end
      // port registers are read only; stray addresses read zero
      ahb(1'b1, 32'h20, 32'hFFFF_FFFF);
      ahb(1'b0, 32'h20, 32'h0);
      check("ro port", rd, {16'h0, exp_w[0] & 16'hFE7F});
      foreach (exp_w[k])
      begin
         ahb(1'b0, k[0] ? 32'h104 : 32'h10 + 32'(k), 32'h0);
         check("unmapped", rd, 32'h0);
      end
      print_verdict();
   end
endmodule : pcwl_loader_tb
